// ===== rtl/rt_interrupt_logic.sv
// Rt_event_enable, pending and line-enable registers with log and summary
`timescale 1ns/10ps
// What this block does
// - One bit position means one event in enable, pending, line-enable.
// - Events with enable bit clear set no pending, log, summary or line bit.
// - Events before an enable is set are never recognised later.
// - Each message with an enabled event writes one entry to the log.
// - Enabled events OR into the pending register, keeping older bits.
// - Enabled events set the terminal summary bit 1 of hardware pending.
// - Summary set whenever a message sets any pending bit; bit 1 used.
// - Line-enabled events assert the active-low interrupt at message end.
// - Non line-enabled events update pending and log but not the line.
// - Reading the pending register returns it then clears it.
// - One interrupt line is the OR of all line-enabled pending sources.
// - Mask option suppresses the line for illegal or busy messages.
// - Logged word reproduces the RT pending bits.
// - Pending bit 9 reads zero; log bit 9 flags busy when option set.
// - Busy alone is never an interrupt event.
// - Bit 7 is index-zero, bit 6 is illegal command.
// - Disabled reset mode code raises reset request only.
module rt_interrupt_logic
  import rt_irq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Message completion events from the terminal
  input  wire logic        msgDone,
  input  wire logic [15:0] msgEvents,
  input  wire logic        msgIllegal,
  input  wire logic        msgBusy,
  // Other pending sources
  input  wire logic [15:0] hwEventSet,
  input  wire logic [15:0] bcPending,
  // Log buffer write
  output logic             logValid,
  output logic      [15:0] loggedEventWord,
  // Outputs
  output logic             terminalResetRequest,
  output logic             irq_n
);

  // ****************************************************************
  // State
  // ****************************************************************
  bus_req_s    req;
  msg_evt_s    msg;
  log_wr_s     logR, logNxt;
  logic [15:0] enableR, enableNxt;
  logic [15:0] lineEnR, lineEnNxt;
  logic [15:0] pendR, pendNxt;
  logic [15:0] hwPendR, hwPendNxt;
  logic [15:0] hwLineEnR, hwLineEnNxt;
  logic [15:0] bcLineEnR, bcLineEnNxt;
  logic [15:0] extCfgR, extCfgNxt;
  logic [15:0] lineSrcR, lineSrcNxt;
  logic [15:0] quietR, quietNxt;
  logic [15:0] rdataR, rdataNxt;
  logic        rstReqR, rstReqNxt;
  logic [15:0] hits;
  logic [15:0] pendAfter;

  function automatic logic isReg(input logic [7:0] a, input logic [7:0] idx);
    return a == idx;
  endfunction

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign msg = '{valid: msgDone, events: msgEvents, illegal: msgIllegal, busy: msgBusy};

  // ****************************************************************
  // Event qualification
  // ****************************************************************
  // drop disabled events
  // only live enables count, no history kept
  // busy is never an event bit
  // index-zero and illegal bits pass as-is
  always_comb begin
    hits = msg.valid ? (msg.events & enableR & PENDING_WMASK) : REG_RESET;
  end

  always_comb begin
    pendAfter = pendR;
    if (req.rd && isReg(req.addr, RT_PENDING_IDX)) begin
      pendAfter = REG_RESET;
    end
  end

  // ****************************************************************
  // Register next values
  // ****************************************************************
  always_comb begin
    enableNxt   = enableR;
    lineEnNxt   = lineEnR;
    hwLineEnNxt = hwLineEnR;
    bcLineEnNxt = bcLineEnR;
    extCfgNxt   = extCfgR;
    hwPendNxt   = hwPendR | hwEventSet;
    rdataNxt    = REG_RESET;
    if (req.wr) begin
      case (req.addr)
        RT_ENABLE_IDX:  enableNxt   = req.wdata;
        RT_LINE_EN_IDX: lineEnNxt   = req.wdata;
        HW_LINE_EN_IDX: hwLineEnNxt = req.wdata;
        BC_LINE_EN_IDX: bcLineEnNxt = req.wdata;
        EXT_CONFIG_IDX: extCfgNxt   = req.wdata;
        default:        extCfgNxt   = extCfgR;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        RT_PENDING_IDX: rdataNxt = pendR & PENDING_WMASK;
        RT_ENABLE_IDX:  rdataNxt = enableR;
        RT_LINE_EN_IDX: rdataNxt = lineEnR;
        HW_LINE_EN_IDX: rdataNxt = hwLineEnR;
        BC_LINE_EN_IDX: rdataNxt = bcLineEnR;
        EXT_CONFIG_IDX: rdataNxt = extCfgR;
        HW_PENDING_IDX: rdataNxt = hwPendR;
        default:        rdataNxt = REG_RESET;
      endcase
      // Hardware pending also clears on read
      if (isReg(req.addr, HW_PENDING_IDX)) begin
        hwPendNxt = hwEventSet;
      end
    end
    // summary bit 1 ORed, bit 0 follows bcPending, other bits kept
    // set whenever any pending bit set
    if (|hits) begin
      hwPendNxt[TERM_SUMMARY_BIT] = 1'b1;
    end
    hwPendNxt[CTRL_SUMMARY_BIT] = |bcPending;
  end

  // ****************************************************************
  // Pending, log and line sources
  // ****************************************************************
  always_comb begin
    // OR in, set wins over read clear
    // same bit position in all three
    pendNxt = pendAfter | hits;
    // bit 9 flags busy when option set
    logNxt.valid = |hits;
    logNxt.word  = pendNxt & PENDING_WMASK;
    if (extCfgR[BUSY_LOG_BIT] && msg.busy) begin
      logNxt.word[BUSY_FLAG_BIT] = 1'b1;
    end
    // line-enabled bits drive the line at message end
    // other bits stay off the line
    // masked messages leave their new bits quiet
    // Quiet until read or until an unmasked message sets the bit, so the line never rises a cycle later
    quietNxt = quietR & pendAfter;
    if (msg.valid && extCfgR[LINE_MASK_BIT] && (msg.illegal || msg.busy)) begin
      quietNxt = quietNxt | (hits & ~pendAfter);
    end else begin
      quietNxt = quietNxt & ~hits;
    end
    lineSrcNxt = pendNxt & lineEnR & ~quietNxt;
    // disabled reset mode code goes to its own pin
    rstReqNxt = msg.valid && msg.events[RESET_REQ_BIT] && !enableR[RESET_REQ_BIT];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      enableR   <= REG_RESET;
      lineEnR   <= REG_RESET;
      pendR     <= REG_RESET;
      hwPendR   <= REG_RESET;
      hwLineEnR <= REG_RESET;
      bcLineEnR <= REG_RESET;
      extCfgR   <= REG_RESET;
      lineSrcR  <= REG_RESET;
      quietR    <= REG_RESET;
      rdataR    <= REG_RESET;
      rstReqR   <= 1'b0;
      logR      <= '0;
    end else begin
      enableR   <= enableNxt;
      lineEnR   <= lineEnNxt;
      pendR     <= pendNxt;
      hwPendR   <= hwPendNxt;
      hwLineEnR <= hwLineEnNxt;
      bcLineEnR <= bcLineEnNxt;
      extCfgR   <= extCfgNxt;
      lineSrcR  <= lineSrcNxt;
      quietR    <= quietNxt;
      rdataR    <= rdataNxt;
      rstReqR   <= rstReqNxt;
      logR      <= logNxt;
    end
  end

  assign rdata                = rdataR;
  assign logValid             = logR.valid;
  assign loggedEventWord      = logR.word;
  assign terminalResetRequest = rstReqR;

  // ****************************************************************
  // Shared interrupt line
  // ****************************************************************
  rt_irq_line u_line (
    .clk       (clk),
    .arst_n    (arst_n),
    .hwPending (hwPendR),
    .hwLineEn  (hwLineEnR),
    .bcPending (bcPending),
    .bcLineEn  (bcLineEnR),
    .rtLineSrc (lineSrcR),
    .irq_n     (irq_n)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence enabledEvent(int b);
    msgDone && msgEvents[b] && enableR[b];
  endsequence

  disabledDropped_a: assert property (@(posedge clk) disable iff (!arst_n)
    (msgDone && ((msgEvents & ~enableR) != 16'h0000) && ((msgEvents & enableR) == 16'h0000)
      && !rd) |=> (pendR == $past(pendR)) && !logValid)
    else $error("disabled event changed pending or log");

  pendingSets_a: assert property (@(posedge clk) disable iff (!arst_n)
    enabledEvent(INDEX_ZERO_BIT) |=> pendR[INDEX_ZERO_BIT])
    else $error("enabled event did not set pending");

  pendingKeeps_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!(rd && addr == RT_PENDING_IDX)) |=> ((pendR & $past(pendR)) == $past(pendR)))
    else $error("pending bit lost without read");

  summarySets_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|hits) |=> hwPendR[TERM_SUMMARY_BIT]) else $error("summary bit not set");

  logWritten_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|hits) |=> logValid && ((loggedEventWord & PENDING_WMASK) == (pendR & PENDING_WMASK)))
    else $error("log entry missing or not mirroring pending");

  readClears_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rd && addr == RT_PENDING_IDX && !msgDone) |=> (pendR == 16'h0000) && (rdata == $past(pendR)))
    else $error("pending read did not return and clear");

  bitNineZero_a: assert property (@(posedge clk) disable iff (!arst_n)
    !pendR[BUSY_FLAG_BIT]) else $error("pending bit 9 set");

  lineHeld_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|(pendR & lineEnR & ~quietR)) && !msgDone && !rd |=> ##1 !irq_n)
    else $error("line dropped while line-enabled pending");

  quietLine_a: assert property (@(posedge clk) disable iff (!arst_n)
    (msgDone && extCfgR[LINE_MASK_BIT] && (msgIllegal || msgBusy))
      |=> ((lineSrcR & ~$past(pendR)) == 16'h0000))
    else $error("masked message put new bits on the line");

  resetReq_a: assert property (@(posedge clk) disable iff (!arst_n)
    (msgDone && msgEvents[RESET_REQ_BIT] && !enableR[RESET_REQ_BIT]) |=> terminalResetRequest)
    else $error("reset request not raised");

endmodule

// ===== inc/rt_irq_pkg.sv
// Package: register map, field positions and carriers for the RT interrupt logic
package rt_irq_pkg;

  // ****************************************************************
  // Register indices (byte address is index times four)
  // ****************************************************************
  localparam logic [7:0] HW_PENDING_IDX  = 8'h06;
  localparam logic [7:0] RT_PENDING_IDX  = 8'h09;
  localparam logic [7:0] RT_ENABLE_IDX   = 8'h12;
  localparam logic [7:0] RT_LINE_EN_IDX  = 8'h16;
  localparam logic [7:0] EXT_CONFIG_IDX  = 8'h4d;
  localparam logic [7:0] HW_LINE_EN_IDX  = 8'h60;
  localparam logic [7:0] BC_LINE_EN_IDX  = 8'h61;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          TERM_SUMMARY_BIT = 1;
  localparam int          CTRL_SUMMARY_BIT = 0;
  localparam int          LINE_MASK_BIT    = 0;
  localparam int          BUSY_LOG_BIT     = 2;
  localparam int          BUSY_FLAG_BIT    = 9;
  localparam int          INDEX_ZERO_BIT   = 7;
  localparam int          ILLEGAL_CMD_BIT  = 6;
  localparam int          RESET_REQ_BIT    = 8;
  localparam logic [15:0] REG_RESET        = 16'h0000;
  localparam logic [15:0] PENDING_WMASK    = 16'hfdff;

  // Bus request from the host
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  // One completed message worth of events
  typedef struct packed {
    logic        valid;
    logic [15:0] events;
    logic        illegal;
    logic        busy;
  } msg_evt_s;

  // Log buffer write
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } log_wr_s;

endpackage

// ===== rtl/rt_irq_line.sv
// Host interrupt line: OR of line-enabled pending bits across all sources
`timescale 1ns/10ps
module rt_irq_line
  import rt_irq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Pending and line enables
  input  wire logic [15:0] hwPending,
  input  wire logic [15:0] hwLineEn,
  input  wire logic [15:0] bcPending,
  input  wire logic [15:0] bcLineEn,
  input  wire logic [15:0] rtLineSrc,
  // Interrupt pin, active low
  output logic             irq_n
);

  logic irqNxt;
  logic irqR;

  always_comb begin
    irqNxt = |(hwPending & hwLineEn) | |(bcPending & bcLineEn) | |rtLineSrc;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqR <= 1'b0;
    end else begin
      irqR <= irqNxt;
    end
  end

  assign irq_n = ~irqR;

  lineFollows_a: assert property (@(posedge clk) disable iff (!arst_n)
    (|rtLineSrc) |=> !irq_n) else $error("irq line missed an RT source");

endmodule

// ===== tb/rt_host_model.sv
// Host processor model: register master and interrupt service helpers
`timescale 1ns/10ps
module rt_host_model
  import rt_irq_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register port
  output logic      [7:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [15:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // ****************************************************************
  // Service
  // ****************************************************************
  // summary then RT pending
  task automatic service(output logic [15:0] hw, output logic [15:0] rt);
    read_reg(HW_PENDING_IDX, hw);
    rt = 16'h0000;
    if (hw[TERM_SUMMARY_BIT] === 1'b1) begin
      read_reg(RT_PENDING_IDX, rt);
    end
  endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking testbench for the RT interrupt logic
`timescale 1ns/10ps
module tb_top
  import rt_irq_pkg::*;
;
  logic        clk;
  logic        arst_n;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        msgDone;
  logic [15:0] msgEvents;
  logic        msgIllegal;
  logic        msgBusy;
  logic [15:0] hwEventSet;
  logic [15:0] bcPending;
  logic        logValid;
  logic [15:0] loggedEventWord;
  logic        terminalResetRequest;
  logic        irq_n;
  logic [15:0] d;
  logic [15:0] h;
  logic        lv;
  logic [15:0] lw;
  logic        rr;
  logic        irq2;
  int          err_count;
  int          num_checks;

  rt_interrupt_logic u_rt_interrupt_logic (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .msgDone(msgDone),
    .msgEvents(msgEvents), .msgIllegal(msgIllegal), .msgBusy(msgBusy),
    .hwEventSet(hwEventSet), .bcPending(bcPending), .logValid(logValid),
    .loggedEventWord(loggedEventWord), .terminalResetRequest(terminalResetRequest),
    .irq_n(irq_n));
  rt_host_model u_rt_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Samples log and reset request after one edge, the line after two
  task automatic send(input logic [15:0] ev, input logic il, input logic bz);
    @(posedge clk);
    msgDone <= 1'b1;
    msgEvents <= ev;
    msgIllegal <= il;
    msgBusy <= bz;
    @(posedge clk);
    msgDone <= 1'b0;
    #1;
    lv = logValid;
    lw = loggedEventWord;
    rr = terminalResetRequest;
    @(posedge clk);
    #1;
    irq2 = irq_n;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    u_rt_host_model.read_reg(a, d);
    chk(d, exp);
  endtask

  // ****************************************************************
  // Clock, reset, watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200us;
    err_count++;
    print_verdict();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    err_count = 0;
    num_checks = 0;
    arst_n = 1'b0;
    msgDone = 1'b0;
    msgEvents = 16'h0000;
    msgIllegal = 1'b0;
    msgBusy = 1'b0;
    hwEventSet = 16'h0000;
    bcPending = 16'h0000;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk({15'h0000, irq_n}, 16'h0001);
    rd_chk(RT_PENDING_IDX, REG_RESET);
    rd_chk(RT_ENABLE_IDX, REG_RESET);
    rd_chk(RT_LINE_EN_IDX, REG_RESET);
    rd_chk(8'hff, 16'h0000);
    send(16'h0080, 1'b0, 1'b0);
    chk({15'h0000, lv}, 16'h0000);
    u_rt_host_model.write_reg(RT_ENABLE_IDX, 16'h00c0);
    rd_chk(RT_ENABLE_IDX, 16'h00c0);
    rd_chk(RT_PENDING_IDX, 16'h0000);
    u_rt_host_model.write_reg(RT_LINE_EN_IDX, 16'h0080);
    send(16'h0040, 1'b0, 1'b0);
    chk({lv, lw[14:0]}, 16'h8040);
    chk({15'h0000, irq2}, 16'h0001);
    send(16'h0080, 1'b0, 1'b0);
    chk(lw, 16'h00c0);
    chk({15'h0000, irq2}, 16'h0000);
    u_rt_host_model.service(h, d);
    chk(h & 16'h0002, 16'h0002);
    chk(d, 16'h00c0);
    rd_chk(RT_PENDING_IDX, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq_n}, 16'h0001);
    u_rt_host_model.write_reg(EXT_CONFIG_IDX, 16'h0004);
    u_rt_host_model.write_reg(RT_ENABLE_IDX, 16'h02c0);
    send(16'h0240, 1'b0, 1'b1);
    chk(lw, 16'h0240);
    rd_chk(RT_PENDING_IDX, 16'h0040);
    send(16'h0000, 1'b0, 1'b1);
    chk({15'h0000, lv}, 16'h0000);
    u_rt_host_model.write_reg(EXT_CONFIG_IDX, 16'h0001);
    u_rt_host_model.write_reg(RT_LINE_EN_IDX, 16'h0040);
    send(16'h0040, 1'b1, 1'b0);
    chk({14'h0000, lv, irq2}, 16'h0003);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq_n}, 16'h0001);
    rd_chk(RT_PENDING_IDX, 16'h0040);
    send(16'h0040, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq_n}, 16'h0001);
    rd_chk(RT_PENDING_IDX, 16'h0040);
    send(16'h0040, 1'b0, 1'b0);
    chk({15'h0000, irq2}, 16'h0000);
    rd_chk(RT_PENDING_IDX, 16'h0040);
    send(16'h0100, 1'b0, 1'b0);
    chk({14'h0000, rr, lv}, 16'h0002);
    rd_chk(RT_PENDING_IDX, 16'h0000);
    u_rt_host_model.write_reg(HW_LINE_EN_IDX, 16'h0010);
    u_rt_host_model.write_reg(BC_LINE_EN_IDX, 16'h0001);
    @(posedge clk);
    hwEventSet <= 16'h0010;
    @(posedge clk);
    hwEventSet <= 16'h0000;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, irq_n}, 16'h0000);
    rd_chk(HW_PENDING_IDX, 16'h0012);
    @(posedge clk);
    bcPending <= 16'h0001;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, irq_n}, 16'h0000);
    rd_chk(HW_PENDING_IDX, 16'h0001);
    @(posedge clk);
    bcPending <= 16'h0000;
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0000, irq_n}, 16'h0001);
    print_verdict();
  end
endmodule
